// *** design/nstg_pkg.sv ***
// Shared constants and types for the NAND strobe timing generator.
package nstg_pkg;

  // Source clock and controller clock limits, in kHz.
  localparam int unsigned CLK_KHZ          = 200000;
  localparam int unsigned MAX_CTRL_KHZ     = 66000;
  localparam int unsigned DEFAULT_CTRL_KHZ = 16630;

  // Divider ratio width and the ratios derived from the limits above.
  localparam int DIV_W = 6;
  // Least ratio that keeps the controller clock at or below its limit,
  // rounded up and then made even so both half periods are equal.
  localparam int unsigned MIN_DIV_RAW =
    (CLK_KHZ + MAX_CTRL_KHZ - 1) / MAX_CTRL_KHZ;
  localparam logic [DIV_W-1:0] MIN_DIV =
    DIV_W'(MIN_DIV_RAW + (MIN_DIV_RAW % 2));
  // Ratio giving the power-up controller clock, rounded to nearest.
  localparam logic [DIV_W-1:0] DEFAULT_DIV =
    DIV_W'((CLK_KHZ + DEFAULT_CTRL_KHZ / 2) / DEFAULT_CTRL_KHZ);

  // Phase lengths, in half periods of the controller clock.
  localparam int PH_W = 4;
  localparam logic [PH_W-1:0] WR_SETUP_HALVES = 4'h2;
  localparam logic [PH_W-1:0] WR_PULSE_HALVES = 4'h2;
  localparam logic [PH_W-1:0] WR_HOLD_HALVES  = 4'h2;
  localparam logic [PH_W-1:0] RD_READY_HALVES = 4'h8;
  localparam logic [PH_W-1:0] RD_LOW_HALVES   = 4'h3;
  localparam logic [PH_W-1:0] RD_HIGH_HALVES  = 4'h1;

  // Read data window at the capture edge, in ns, and in source cycles.
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RD_SETUP_NS     = 15;
  localparam int unsigned RD_HOLD_NS      = 0;
  localparam int unsigned RD_SETUP_CYCLES =
    (RD_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Data bus width.
  localparam int DATA_W = 8;

  // Kinds of bus operation.
  typedef enum logic [1:0] {
    NSTG_OP_CMD  = 2'h0,
    NSTG_OP_ADDR = 2'h1,
    NSTG_OP_DATA = 2'h2,
    NSTG_OP_READ = 2'h3
  } nstg_op_e;

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    NSTG_IDLE   = 7'h01,
    NSTG_WSETUP = 7'h02,
    NSTG_WPULSE = 7'h04,
    NSTG_WHOLD  = 7'h08,
    NSTG_RWAIT  = 7'h10,
    NSTG_RLOW   = 7'h20,
    NSTG_RHIGH  = 7'h40
  } nstg_state_e;

endpackage : nstg_pkg

// *** design/nstg_top.sv ***
// Strobe sequencer driving a NAND flash command, address and data bus.
`timescale 1ns/1ps
module nstg_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic [nstg_pkg::DIV_W-1:0]  flash_clk_divider_in,
  input  wire logic                        div_load_in,
  input  wire logic                        op_valid_in,
  input  wire nstg_pkg::nstg_op_e          op_kind_in,
  input  wire logic [nstg_pkg::DATA_W-1:0] op_data_in,
  output logic                             op_ready_out,
  output logic                             op_done_out,
  output logic [nstg_pkg::DATA_W-1:0]      rd_data_out,
  output logic                             rd_valid_out,
  output logic                             flash_chip_sel_n_out,
  output logic                             cmd_latch_en_out,
  output logic                             addr_latch_en_out,
  output logic                             flash_write_strobe_n_out,
  output logic                             flash_read_strobe_n_out,
  output logic [nstg_pkg::DATA_W-1:0]      flash_data_out,
  output logic                             flash_data_oe_out,
  input  wire logic [nstg_pkg::DATA_W-1:0] flash_data_in,
  input  wire logic                        flash_ready_in
);
  import nstg_pkg::*;

  nstg_state_e             state;
  nstg_state_e             next_state;
  nstg_op_e                op_kind;
  nstg_op_e                kind_now;
  logic [DIV_W-1:0]        div_ratio;
  logic [DIV_W-2:0]        half_cnt;
  logic [DIV_W-2:0]        half_len;
  logic                    half_tick;
  logic [PH_W-1:0]         phase;
  logic                    accept;
  logic                    ready_meta;
  logic                    ready_sync;
  logic [DATA_W-1:0]       data_meta;
  logic [DATA_W-1:0]       data_sync;
  logic                    write_next;

  // A new operation is taken only while the sequencer is idle.
  assign accept   = op_valid_in && (state == NSTG_IDLE);
  assign kind_now = (state == NSTG_IDLE) ? op_kind_in : op_kind;
  assign half_len = div_ratio[DIV_W-1:1];

  // Ratio store: power-up default until software loads a new one.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_ratio <= DEFAULT_DIV;
    end else if (div_load_in) begin
      if (flash_clk_divider_in < MIN_DIV) begin
        div_ratio <= MIN_DIV;
      end else begin
        div_ratio <= flash_clk_divider_in;
      end
    end
  end

  // Half-period enable divider. It restarts on each accepted operation
  // so that every phase is an exact number of half periods long; the
  // price is that the controller clock is not free running. While the
  // read wait sees ready low the divider is held at zero, so the first
  // half period counted once ready returns is a whole one.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      half_cnt <= '0;
    end else if (accept || half_tick) begin
      half_cnt <= '0;
    end else if (state == NSTG_RWAIT && !ready_sync) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  assign half_tick = (state != NSTG_IDLE) && (half_cnt == half_len - 1'b1);

  // Two-stage synchronisers for the ready pin and the read data bus.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
      data_meta  <= '0;
      data_sync  <= '0;
    end else begin
      ready_meta <= flash_ready_in;
      ready_sync <= ready_meta;
      data_meta  <= flash_data_in;
      data_sync  <= data_meta;
    end
  end

  // Next-state decode; every phase ends on a half tick.
  always_comb begin
    next_state = state;
    case (state)
      NSTG_IDLE: begin
        if (op_valid_in) begin
          if (op_kind_in == NSTG_OP_READ) begin
            next_state = NSTG_RWAIT;
          end else begin
            next_state = NSTG_WSETUP;
          end
        end
      end
      NSTG_WSETUP: begin
        if (half_tick && phase == WR_SETUP_HALVES - 1'b1) begin
          next_state = NSTG_WPULSE;
        end
      end
      NSTG_WPULSE: begin
        if (half_tick && phase == WR_PULSE_HALVES - 1'b1) begin
          next_state = NSTG_WHOLD;
        end
      end
      NSTG_WHOLD: begin
        if (half_tick && phase == WR_HOLD_HALVES - 1'b1) begin
          next_state = NSTG_IDLE;
        end
      end
      NSTG_RWAIT: begin
        if (half_tick && ready_sync &&
            phase == RD_READY_HALVES - 1'b1) begin
          next_state = NSTG_RLOW;
        end
      end
      NSTG_RLOW: begin
        if (half_tick && phase == RD_LOW_HALVES - 1'b1) begin
          next_state = NSTG_RHIGH;
        end
      end
      NSTG_RHIGH: begin
        if (half_tick && phase == RD_HIGH_HALVES - 1'b1) begin
          next_state = NSTG_IDLE;
        end
      end
      default: begin
        next_state = NSTG_IDLE;
      end
    endcase
  end

  // State register and latched operation.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state   <= NSTG_IDLE;
      op_kind <= NSTG_OP_CMD;
    end else begin
      state <= next_state;
      if (accept) begin
        op_kind <= op_kind_in;
      end
    end
  end

  // Half-period count within a phase. Ready low during the wait starts
  // the count again, so the four periods are counted with ready held.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= '0;
    end else if (next_state != state) begin
      phase <= '0;
    end else if (state == NSTG_RWAIT && !ready_sync) begin
      phase <= '0;
    end else if (half_tick) begin
      phase <= phase + 1'b1;
    end
  end

  assign write_next = (next_state == NSTG_WSETUP) ||
                      (next_state == NSTG_WPULSE) ||
                      (next_state == NSTG_WHOLD);

  // Pin drivers, registered from the next state so each pin changes in
  // the same edge as the state. Latches drop with the last hold phase.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_chip_sel_n_out     <= 1'b1;
      cmd_latch_en_out         <= 1'b0;
      addr_latch_en_out        <= 1'b0;
      flash_write_strobe_n_out <= 1'b1;
      flash_read_strobe_n_out  <= 1'b1;
      flash_data_oe_out        <= 1'b0;
    end else begin
      flash_chip_sel_n_out     <= (next_state == NSTG_IDLE);
      cmd_latch_en_out         <= write_next &&
                                  (kind_now == NSTG_OP_CMD);
      addr_latch_en_out        <= write_next &&
                                  (kind_now == NSTG_OP_ADDR);
      flash_write_strobe_n_out <= (next_state != NSTG_WPULSE);
      flash_read_strobe_n_out  <= (next_state != NSTG_RLOW);
      flash_data_oe_out        <= write_next;
    end
  end

  // Write data is set on accept and kept until the next write is taken.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_data_out <= '0;
    end else if (accept && op_kind_in != NSTG_OP_READ) begin
      flash_data_out <= op_data_in;
    end
  end

  // Read capture at the rising read strobe edge. The data seen here left
  // the pins two cycles earlier through the synchroniser, which adds those
  // two cycles to the setup window the flash must meet.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      if (state == NSTG_RLOW && next_state == NSTG_RHIGH) begin
        rd_data_out  <= data_sync;
        rd_valid_out <= 1'b1;
      end
    end
  end

  // Handshake to the user side.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_ready_out <= 1'b1;
      op_done_out  <= 1'b0;
    end else begin
      op_ready_out <= (next_state == NSTG_IDLE);
      op_done_out  <= (state != NSTG_IDLE) && (next_state == NSTG_IDLE);
    end
  end

endmodule : nstg_top

// *** tb/nstg_top_properties.sv ***
// Port-level timing checker for the NAND strobe sequencer.
`timescale 1ns/1ps
module nstg_props import nstg_pkg::*; (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic [DIV_W-1:0]  flash_clk_divider_in,
  input wire logic              div_load_in,
  input wire logic              op_ready_out,
  input wire logic              op_done_out,
  input wire logic [DATA_W-1:0] rd_data_out,
  input wire logic              rd_valid_out,
  input wire logic              flash_chip_sel_n_out,
  input wire logic              cmd_latch_en_out,
  input wire logic              addr_latch_en_out,
  input wire logic              flash_write_strobe_n_out,
  input wire logic              flash_read_strobe_n_out,
  input wire logic [DATA_W-1:0] flash_data_out,
  input wire logic              flash_data_oe_out,
  input wire logic [DATA_W-1:0] flash_data_in,
  input wire logic              flash_ready_in
);
  logic [DIV_W-1:0] ratio;
  logic [7:0]       h, we_lo, we_hi, sel_lo, re_lo, rdy_hi;
  assign h = 8'(ratio[DIV_W-1:1]);
  // Saturating run length, so long idle stretches never wrap to zero.
  function automatic logic [7:0] step(input logic [7:0] c, input logic on);
    return on ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00;
  endfunction : step
  // Expected ratio; loads below the legal minimum are raised to it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) ratio <= DEFAULT_DIV;
    else if (div_load_in) ratio <= (flash_clk_divider_in < MIN_DIV) ?
                                   MIN_DIV : flash_clk_divider_in;
  end
  // Run lengths of both write strobe levels, the low chip select and read strobe, and the high ready line.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {we_lo, sel_lo, re_lo, rdy_hi} <= 32'h0;
      we_hi <= 8'hFF;
    end else begin
      we_lo  <= step(we_lo, !flash_write_strobe_n_out);
      we_hi  <= step(we_hi, flash_write_strobe_n_out);
      sel_lo <= step(sel_lo, !flash_chip_sel_n_out);
      re_lo  <= step(re_lo, !flash_read_strobe_n_out);
      rdy_hi <= step(rdy_hi, flash_ready_in);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reset_idle_a: assert property ($fell(rst_in) |-> flash_chip_sel_n_out &&
    flash_write_strobe_n_out && flash_read_strobe_n_out && !cmd_latch_en_out
    && !addr_latch_en_out && !flash_data_oe_out) else $error("not idle");
  wr_pulse_a: assert property ($rose(flash_write_strobe_n_out) |->
    we_lo == 2 * h) else $error("write pulse length");
  wr_setup_a: assert property ($fell(flash_write_strobe_n_out) |->
    sel_lo >= 2 * h && flash_data_oe_out && $stable(flash_data_out) &&
    !(cmd_latch_en_out && addr_latch_en_out)) else $error("write setup");
  wr_hold_a: assert property ($rose(flash_chip_sel_n_out) &&
    $past(flash_data_oe_out) |-> we_hi >= 2 * h) else $error("write hold");
  wr_gap_a: assert property ($fell(flash_write_strobe_n_out) |->
    we_hi >= 2 * h) else $error("write strobe gap");
  rd_wait_a: assert property ($fell(flash_read_strobe_n_out) |->
    rdy_hi >= 8 * h && flash_write_strobe_n_out) else $error("ready wait");
  rd_low_a: assert property ($rose(flash_read_strobe_n_out) |->
    re_lo == 3 * h && rd_valid_out) else $error("read pulse length");
  rd_data_a: assert property (rd_valid_out |->
    rd_data_out == $past(flash_data_in, 3)) else $error("read capture");
  done_idle_a: assert property (op_done_out |-> op_ready_out &&
    flash_chip_sel_n_out && !cmd_latch_en_out && !addr_latch_en_out ##1
    !op_done_out) else $error("done pulse");
endmodule : nstg_props
bind nstg_top nstg_props chk (.*);

// *** tb/nstg_flash_model.sv ***
// Behavioural NAND flash: busy after each operation, drives read data.
`timescale 1ns/1ps
module nstg_flash_model import nstg_pkg::*; #(parameter int BUSY = 9) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              chip_sel_n_in,
  input  wire logic              read_strobe_n_in,
  input  wire logic [DATA_W-1:0] rd_byte_in,
  output logic                   ready_out,
  output logic [DATA_W-1:0]      data_out
);
  logic       sel_q;
  logic [7:0] busy;
  assign ready_out = (busy == 8'h00);
  // Busy after each deselect; bus toggles when released so stale data fails.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q    <= 1'b1;
      busy     <= 8'h00;
      data_out <= 8'h00;
    end else begin
      sel_q    <= chip_sel_n_in;
      busy     <= (chip_sel_n_in && !sel_q) ? 8'(BUSY) :
                  busy - 8'(busy != 8'h00);
      data_out <= read_strobe_n_in ? ~data_out : rd_byte_in;
    end
  end
endmodule : nstg_flash_model

// *** tb/nstg_top_tb.sv ***
// Self-checking bench for the NAND strobe sequencer.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module nstg_top_tb;
  import nstg_pkg::*;
  logic clk_in, rst_in, load, valid, ready, done, rd_valid, sel_n, cle, ale;
  logic we_n, re_n, oe, f_rdy;
  logic [DIV_W-1:0]  div;
  logic [DATA_W-1:0] data, rd_data, fd_out, fd_in, rd_byte;
  nstg_op_e kind;
  int bad_count, cmp_count, seed, h;
  logic [DIV_W-1:0] rat [5] = '{6'h0C, 6'h02, 6'h08, 6'h09, 6'h04};
  nstg_top uut (.clk_in(clk_in), .rst_in(rst_in), .flash_clk_divider_in(div),
    .div_load_in(load), .op_valid_in(valid), .op_kind_in(kind),
    .op_data_in(data), .op_ready_out(ready), .op_done_out(done),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .flash_chip_sel_n_out(sel_n), .cmd_latch_en_out(cle),
    .addr_latch_en_out(ale), .flash_write_strobe_n_out(we_n),
    .flash_read_strobe_n_out(re_n), .flash_data_out(fd_out),
    .flash_data_oe_out(oe), .flash_data_in(fd_in), .flash_ready_in(f_rdy));
  nstg_flash_model flash (.clk_in(clk_in), .rst_in(rst_in),
    .chip_sel_n_in(sel_n), .read_strobe_n_in(re_n), .rd_byte_in(rd_byte),
    .ready_out(f_rdy), .data_out(fd_in));
  always #2.5 clk_in = ~clk_in;
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  // Half period in source cycles once the lower ratio clamp is applied.
  function automatic int exp_half(input logic [DIV_W-1:0] r);
    return ((r < MIN_DIV) ? int'(MIN_DIV) : int'(r)) >> 1;
  endfunction : exp_half
  // One operation; the next call follows done at once, back to back, unless a ratio load tick comes between them.
  task automatic do_op(input nstg_op_e k, input logic [7:0] b);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 4000) begin tick(); n++; end
    if (n >= 4000) begin bad_count++; wrap_up(); end
    valid   = 1'b1;
    kind    = k;
    data    = b;
    rd_byte = b;
    tick();
    valid = 1'b0;
    `CHK(sel_n, 1'b0)
    if (k != NSTG_OP_READ) begin
      `CHK({cle, ale}, {k == NSTG_OP_CMD, k == NSTG_OP_ADDR})
      `CHK({oe, fd_out}, {1'b1, b})
    end
    n = 0;
    while (done !== 1'b1 && n < 4000) begin tick(); n++; end
    if (n >= 4000) begin bad_count++; wrap_up(); end
    if (k != NSTG_OP_READ) `CHK(n, 6 * h)
    else `CHK(rd_data, b)
  endtask : do_op
  initial begin
    {clk_in, rst_in, load, valid, data, rd_byte} = {2'b01, 18'h0};
    div  = 6'h0C;
    kind = NSTG_OP_CMD;
    seed = 27978;
    h    = 6;
    repeat (20) @(posedge clk_in);
    #1;
    `CHK({sel_n, we_n, re_n, cle, ale, oe, ready}, 7'h71)
    rst_in = 1'b0;
    foreach (rat[i]) begin
      if (i > 0) begin
        {div, load} = {rat[i], 1'b1};
        tick();
        load = 1'b0;
      end
      h = exp_half(rat[i]);
      for (int k = 0; k < 4; k++) do_op(nstg_op_e'(k), 8'($random(seed)));
    end
    repeat (8) do_op(nstg_op_e'($random(seed) & 3), 8'($random(seed)));
    wrap_up();
  end
endmodule : nstg_top_tb
